// ===== core/ism_pkg.sv
package ism_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int NUM_SIG = 4;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int SEL_W = 4;
    localparam int STAMP_W_DEF = 32;
    localparam int N_SRC_DEF = 16;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned STAMP_RES_NS = 1000000;
    localparam int unsigned CLK_PERIOD_NS = 25;
    // least time, rounded up to whole cycles
    localparam int unsigned MS_CYCLES_DEF = (STAMP_RES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_TIME = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_LAST_STAMP = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_EVT_COUNT = 8'h18;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_FILT_LSB = 1;
    localparam int CTRL_OSEL_LSB = 4;
    localparam int CTRL_CSEL_LSB = 8;
    localparam int CTRL_OINV_BIT = 12;
    localparam int CTRL_CINV_BIT = 13;
    localparam int STAT_POS_LSB = 0;
    localparam int STAT_OPEN_BIT = 2;
    localparam int STAT_CLOSED_BIT = 3;
    localparam int STAT_RUN_BIT = 4;
    localparam int STAT_HOT_LSB = 8;
    localparam int IRQ_OFF_LSB = 4;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [2*NUM_SIG-1:0] IRQ_MASK_RST = 8'h00;
    localparam logic [SEL_W-1:0] OSEL_RST = 4'h0;
    localparam logic [SEL_W-1:0] CSEL_RST = 4'h1;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {POS_INTERMEDIATE, POS_OPEN, POS_CLOSED, POS_BAD} ism_pos_type;
    typedef enum logic [1:0] {FILT_BOTH, FILT_ON_ONLY, FILT_OFF_ONLY, FILT_BOTH_ALT} ism_filt_type;

    function automatic logic [NUM_SIG-1:0] ism_onehot(input ism_pos_type p);
        ism_onehot = 4'h1 << p;
    endfunction : ism_onehot

    function automatic logic ism_addr_mapped(input logic [ADDR_W-1:0] a);
        ism_addr_mapped = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_TIME) ||
                          (a == ADDR_IRQ_STATUS) || (a == ADDR_IRQ_MASK) ||
                          (a == ADDR_LAST_STAMP) || (a == ADDR_EVT_COUNT);
    endfunction : ism_addr_mapped

endpackage : ism_pkg

// ===== core/ism_event_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ism_event_if #(parameter int STAMP_W = 32);
    import ism_pkg::*;
    ism_pos_type pos;
    logic [NUM_SIG-1:0] level_hot;
    logic [NUM_SIG-1:0] raw_on;
    logic [NUM_SIG-1:0] raw_off;
    logic [NUM_SIG-1:0] buf_on;
    logic [NUM_SIG-1:0] buf_off;
    logic buf_valid;
    logic [STAMP_W-1:0] buf_stamp;
    modport source(output pos, level_hot, raw_on, raw_off, buf_on, buf_off, buf_valid, buf_stamp);
    modport sink(input pos, level_hot, raw_on, raw_off, buf_on, buf_off, buf_valid, buf_stamp);
endinterface : ism_event_if
`default_nettype wire

// ===== core/ism_ms_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ism_ms_timer #(
    parameter int unsigned MS_CYCLES = ism_pkg::MS_CYCLES_DEF,
    parameter int STAMP_W = ism_pkg::STAMP_W_DEF
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // millisecond count
    output logic [STAMP_W-1:0] stamp
);
    import ism_pkg::*;

    localparam int CNT_W = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(MS_CYCLES - 1);

    logic [CNT_W-1:0] cnt_q;
    logic [STAMP_W-1:0] stamp_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (cnt_q == CNT_LAST) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // wraps silently; software extends it if needed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stamp_q <= '0;
        end else if (cnt_q == CNT_LAST) begin
            stamp_q <= stamp_q + 1'b1; // R11
        end
    end

    assign stamp = stamp_q;

endmodule : ism_ms_timer
`default_nettype wire

// ===== core/ism_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module ism_decoder #(
    parameter int STAMP_W = ism_pkg::STAMP_W_DEF
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // selected status levels
    input wire logic open_lvl,
    input wire logic closed_lvl,
    // settings
    input wire logic run,
    input wire ism_pkg::ism_filt_type filt,
    input wire logic [STAMP_W-1:0] stamp,
    // decoded status and events
    ism_event_if.source evt
);
    import ism_pkg::*;

    localparam logic [NUM_SIG-1:0] HOT_RST = ism_onehot(POS_INTERMEDIATE);

    ism_pos_type pos_d;
    ism_pos_type pos_q;
    logic [NUM_SIG-1:0] hot_d;
    logic [NUM_SIG-1:0] hot_q;
    logic [NUM_SIG-1:0] on_d;
    logic [NUM_SIG-1:0] off_d;
    logic keep_on;
    logic keep_off;
    logic [NUM_SIG-1:0] raw_on_q;
    logic [NUM_SIG-1:0] raw_off_q;
    logic [NUM_SIG-1:0] buf_on_q;
    logic [NUM_SIG-1:0] buf_off_q;
    logic buf_valid_q;
    logic [STAMP_W-1:0] buf_stamp_q;

    always_comb begin
        unique case ({closed_lvl, open_lvl})
            2'b00: pos_d = POS_INTERMEDIATE; // R1
            2'b01: pos_d = POS_OPEN;         // R4
            2'b10: pos_d = POS_CLOSED;       // R5
            2'b11: pos_d = POS_BAD;          // R2
        endcase
    end

    always_comb begin
        hot_d = ism_onehot(pos_d);
        on_d = hot_d & ~ism_onehot(pos_q);  // R10
        off_d = ~hot_d & ism_onehot(pos_q); // R10
    end

    always_comb begin
        unique case (filt)
            FILT_ON_ONLY: begin
                keep_on = 1'b1; // R12
                keep_off = 1'b0;
            end
            FILT_OFF_ONLY: begin
                keep_on = 1'b0; // R12
                keep_off = 1'b1;
            end
            FILT_BOTH, FILT_BOTH_ALT: begin
                keep_on = 1'b1;
                keep_off = 1'b1;
            end
        endcase
    end

    // status held as levels, sampled every edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_q <= POS_INTERMEDIATE; // R15
            hot_q <= HOT_RST;          // R15
        end else begin
            pos_q <= pos_d; // R14
            hot_q <= hot_d; // R13
        end
    end

    // events only while monitoring; changes during setup are silent
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_on_q <= '0; // R15
            raw_off_q <= '0;
            buf_on_q <= '0;
            buf_off_q <= '0;
            buf_valid_q <= 1'b0;
            buf_stamp_q <= '0;
        end else begin
            raw_on_q <= run ? on_d : '0;   // R14
            raw_off_q <= run ? off_d : '0; // R14
            buf_on_q <= (run && keep_on) ? on_d : '0;    // R12
            buf_off_q <= (run && keep_off) ? off_d : '0; // R12
            buf_valid_q <= run && (((keep_on ? on_d : '0) | (keep_off ? off_d : '0)) != '0);
            buf_stamp_q <= stamp; // R11
        end
    end

    assign evt.pos = pos_q;
    assign evt.level_hot = hot_q;
    assign evt.raw_on = raw_on_q;
    assign evt.raw_off = raw_off_q;
    assign evt.buf_on = buf_on_q;
    assign evt.buf_off = buf_off_q;
    assign evt.buf_valid = buf_valid_q;
    assign evt.buf_stamp = buf_stamp_q;

endmodule : ism_decoder
`default_nettype wire

// ===== core/ism_top.sv
// Overview of operation
// R1 - neither input active reports intermediate
// R2 - both inputs active reports bad
// R3 - code: 0 intermediate, 1 open, 2 closed, 3 bad
// R4 - open input high means open position
// R5 - closed input high means closed position
// R6 - normally two separate inputs per object
// R7 - single input may feed inverted copy
// R8 - indication only, no switching command output
// R9 - settings change only in setup phase
// R10 - on and off event per status signal
// R11 - every event carries millisecond timestamp
// R12 - filter passes on, off or both events
// R13 - events cover held status indications too
// R14 - inputs sampled each edge, one-cycle update
// R15 - reset clears strobes, shows intermediate
`timescale 1ns/1ps
`default_nettype none
module ism_top #(
    parameter int N_SRC = ism_pkg::N_SRC_DEF,
    parameter int STAMP_W = ism_pkg::STAMP_W_DEF,
    parameter int unsigned MS_CYCLES = ism_pkg::MS_CYCLES_DEF
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ism_pkg::ADDR_W-1:0] paddr,
    input wire logic [ism_pkg::DATA_W-1:0] pwdata,
    input wire logic [ism_pkg::DATA_W/8-1:0] pstrb,
    output logic [ism_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // status sources: digital inputs and soft signals
    input wire logic [N_SRC-1:0] soft_signal_source,
    // decoded position
    output logic [1:0] position,
    output logic [ism_pkg::NUM_SIG-1:0] position_hot,
    // event buffer port
    output logic position_indicator_events_valid,
    output logic [ism_pkg::NUM_SIG-1:0] position_indicator_events_on,
    output logic [ism_pkg::NUM_SIG-1:0] position_indicator_events_off,
    output logic [STAMP_W-1:0] position_indicator_events_stamp,
    // interrupt
    output logic irq
);
    import ism_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    localparam int IRQ_W = 2 * NUM_SIG;

    logic run_q;
    ism_filt_type filt_q;
    logic [SEL_W-1:0] osel_q;
    logic [SEL_W-1:0] csel_q;
    logic oinv_q;
    logic cinv_q;
    logic open_lvl;
    logic closed_lvl;
    logic [STAMP_W-1:0] stamp_now;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_stat_d;
    logic [IRQ_W-1:0] irq_mask_q;
    logic irq_q;
    logic [STAMP_W-1:0] last_stamp_q;
    logic [DATA_W-1:0] evt_count_q;
    logic [DATA_W-1:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic setup_phase;
    logic wr_take;
    logic [DATA_W-1:0] rd_word;
    logic ro_target;

    ism_event_if #(.STAMP_W(STAMP_W)) evt_bus();

    // ------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------
    function automatic logic pick(input logic [N_SRC-1:0] src, input logic [SEL_W-1:0] sel);
        pick = (int'(sel) < N_SRC) ? src[sel] : 1'b0;
    endfunction : pick

    // inversion lets one physical contact drive both lines
    always_comb begin
        open_lvl = pick(soft_signal_source, osel_q) ^ oinv_q;     // R4 R6 R7
        closed_lvl = pick(soft_signal_source, csel_q) ^ cinv_q;   // R5 R6 R7
    end

    // ------------------------------------------------------------
    // timestamp and decoder
    // ------------------------------------------------------------
    ism_ms_timer #(
        .MS_CYCLES(MS_CYCLES),
        .STAMP_W(STAMP_W)
    ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .stamp(stamp_now)
    );

    ism_decoder #(
        .STAMP_W(STAMP_W)
    ) u_decoder (
        .pclk(pclk),
        .presetn(presetn),
        .open_lvl(open_lvl),
        .closed_lvl(closed_lvl),
        .run(run_q),
        .filt(filt_q),
        .stamp(stamp_now),
        .evt(evt_bus)
    );

    // ------------------------------------------------------------
    // apb handshake
    // ------------------------------------------------------------
    // no wait state: answer comes in the first access cycle
    always_comb begin
        setup_phase = psel && !penable;
        wr_take = psel && penable && pready_q && pwrite;
        ro_target = (paddr == ADDR_STATUS) || (paddr == ADDR_TIME) ||
                    (paddr == ADDR_LAST_STAMP) || (paddr == ADDR_EVT_COUNT);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup_phase;
            pslverr_q <= setup_phase && (!ism_addr_mapped(paddr) || (pwrite && ro_target));
        end
    end

    // ------------------------------------------------------------
    // settings register
    // ------------------------------------------------------------
    // run can always be toggled; the rest freezes while monitoring
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 1'b0;
        end else if (wr_take && paddr == ADDR_CTRL && pstrb[0]) begin
            run_q <= pwdata[CTRL_RUN_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_q <= FILT_BOTH;
            osel_q <= OSEL_RST;
        end else if (wr_take && paddr == ADDR_CTRL && pstrb[0] && !run_q) begin
            filt_q <= ism_filt_type'(pwdata[CTRL_FILT_LSB +: 2]); // R9
            osel_q <= pwdata[CTRL_OSEL_LSB +: SEL_W];             // R9
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            csel_q <= CSEL_RST;
            oinv_q <= 1'b0;
            cinv_q <= 1'b0;
        end else if (wr_take && paddr == ADDR_CTRL && pstrb[1] && !run_q) begin
            csel_q <= pwdata[CTRL_CSEL_LSB +: SEL_W]; // R9
            oinv_q <= pwdata[CTRL_OINV_BIT];          // R9
            cinv_q <= pwdata[CTRL_CINV_BIT];          // R9
        end
    end

    // ------------------------------------------------------------
    // interrupt status, mask and line
    // ------------------------------------------------------------
    // a new event in the clearing cycle stays set
    always_comb begin
        irq_stat_d = irq_stat_q;
        if (wr_take && paddr == ADDR_IRQ_STATUS && pstrb[0]) begin
            irq_stat_d = irq_stat_q & ~pwdata[IRQ_W-1:0];
        end
        irq_stat_d = irq_stat_d | {evt_bus.raw_off, evt_bus.raw_on};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_q <= IRQ_MASK_RST;
        end else if (wr_take && paddr == ADDR_IRQ_MASK && pstrb[0]) begin
            irq_mask_q <= pwdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_d & irq_mask_q);
        end
    end

    // ------------------------------------------------------------
    // event bookkeeping
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_stamp_q <= '0;
        end else if (evt_bus.buf_valid) begin
            last_stamp_q <= evt_bus.buf_stamp;
        end
    end

    // counts buffer writes, saturating so software never sees a wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_count_q <= '0;
        end else if (evt_bus.buf_valid && evt_count_q != '1) begin
            evt_count_q <= evt_count_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        rd_word = '0;
        unique case (paddr)
            ADDR_CTRL: begin
                rd_word[CTRL_RUN_BIT] = run_q;
                rd_word[CTRL_FILT_LSB +: 2] = filt_q;
                rd_word[CTRL_OSEL_LSB +: SEL_W] = osel_q;
                rd_word[CTRL_CSEL_LSB +: SEL_W] = csel_q;
                rd_word[CTRL_OINV_BIT] = oinv_q;
                rd_word[CTRL_CINV_BIT] = cinv_q;
            end
            ADDR_STATUS: begin
                rd_word[STAT_POS_LSB +: 2] = evt_bus.pos; // R3
                rd_word[STAT_OPEN_BIT] = open_lvl;
                rd_word[STAT_CLOSED_BIT] = closed_lvl;
                rd_word[STAT_RUN_BIT] = run_q;
                rd_word[STAT_HOT_LSB +: NUM_SIG] = evt_bus.level_hot;
            end
            ADDR_TIME: begin
                rd_word = DATA_W'(stamp_now);
            end
            ADDR_IRQ_STATUS: begin
                rd_word[IRQ_W-1:0] = irq_stat_q;
            end
            ADDR_IRQ_MASK: begin
                rd_word[IRQ_W-1:0] = irq_mask_q;
            end
            ADDR_LAST_STAMP: begin
                rd_word = DATA_W'(last_stamp_q);
            end
            ADDR_EVT_COUNT: begin
                rd_word = evt_count_q;
            end
            default: begin
                rd_word = '0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (setup_phase && !pwrite) begin
            prdata_q <= rd_word;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // status and events only; nothing here can command the switch
    assign position = evt_bus.pos;                                     // R3 R8
    assign position_hot = evt_bus.level_hot;                           // R13
    assign position_indicator_events_valid = evt_bus.buf_valid;        // R12
    assign position_indicator_events_on = evt_bus.buf_on;              // R10
    assign position_indicator_events_off = evt_bus.buf_off;            // R10
    assign position_indicator_events_stamp = evt_bus.buf_stamp;        // R11
    assign irq = irq_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

endmodule : ism_top
`default_nettype wire

// ===== bench/ism_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module ism_src_model (
    // wanted contact state
    input wire logic single,
    input wire logic [1:0] want,
    // contact lines: bit0 open, bit1 closed
    output logic [1:0] lines
);
    // only one contact wired: its inverse stands in for the other
    assign lines = single ? {~want[0], want[0]} : want;
endmodule : ism_src_model
`default_nettype wire

// ===== bench/ism_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ism_chk #(
    parameter int N_SRC = 16,
    parameter int STAMP_W = 32
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // status and events
    input wire logic [N_SRC-1:0] soft_signal_source,
    input wire logic [1:0] position,
    input wire logic [3:0] position_hot,
    input wire logic position_indicator_events_valid,
    input wire logic [3:0] position_indicator_events_on,
    input wire logic [3:0] position_indicator_events_off,
    input wire logic [STAMP_W-1:0] position_indicator_events_stamp
);
    wire ev = position_indicator_events_valid;
    wire [3:0] eon = position_indicator_events_on;
    wire [3:0] eoff = position_indicator_events_off;
    logic seen_q;
    logic [STAMP_W-1:0] last_q;

    // selects stay at reset values: open on line 0, closed on line 1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_q <= 1'b0;
            last_q <= '0;
        end else if (ev) begin
            seen_q <= 1'b1;
            last_q <= position_indicator_events_stamp;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_decode;
        $past(presetn) |-> position == $past(soft_signal_source[1:0]);
    endproperty
    a_decode: assert property (p_decode) else $error("position not decoded from inputs");
    property p_hot;
        position_hot == (4'h1 << position);
    endproperty
    a_hot: assert property (p_hot) else $error("one-hot status disagrees");
    property p_on_new;
        (eon != 4'h0) |-> eon == position_hot;
    endproperty
    a_on_new: assert property (p_on_new) else $error("on mask not new status");
    property p_off_old;
        (eoff != 4'h0) |-> eoff == $past(position_hot);
    endproperty
    a_off_old: assert property (p_off_old) else $error("off mask not old status");
    property p_quiet;
        $stable(position) |-> eon == 4'h0 && eoff == 4'h0;
    endproperty
    a_quiet: assert property (p_quiet) else $error("event without status change");
    property p_valid;
        ev == ((eon | eoff) != 4'h0);
    endproperty
    a_valid: assert property (p_valid) else $error("valid disagrees with masks");
    property p_stamp;
        ev && seen_q |-> position_indicator_events_stamp >= last_q;
    endproperty
    a_stamp: assert property (p_stamp) else $error("stamp went backwards");
    property p_reset;
        $rose(presetn) |-> position == 2'd0 && !ev;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
    property p_ready;
        psel && !penable |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready in access cycle");
endmodule : ism_chk

bind ism_top ism_chk #(.N_SRC(N_SRC), .STAMP_W(STAMP_W)) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .soft_signal_source(soft_signal_source), .position(position), .position_hot(position_hot),
    .position_indicator_events_valid(position_indicator_events_valid),
    .position_indicator_events_on(position_indicator_events_on),
    .position_indicator_events_off(position_indicator_events_off),
    .position_indicator_events_stamp(position_indicator_events_stamp)
);
`default_nettype wire

// ===== bench/tb_indicator_status_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tb_indicator_status_monitor;
    import ism_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [DATA_W-1:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, ev_valid, single = 1'b0, run_m = 1'b0;
    logic [1:0] want = 2'h0, lines, position, cur = 2'h0, filt_m = 2'h0;
    logic [3:0] position_hot, ev_on, ev_off;
    logic [31:0] ev_stamp, seed = 32'hf0c1;
    logic [13:0] noise = 14'h0;
    logic [7:0] exp_q[$];
    logic [7:0] e_pop;
    int mismatches = 0, n_checks = 0;

    always #12.5 pclk = ~pclk;

    ism_src_model src_u (.single(single), .want(want), .lines(lines));
    ism_top #(.MS_CYCLES(4)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .soft_signal_source({noise, lines}), .position(position),
        .position_hot(position_hot), .position_indicator_events_valid(ev_valid),
        .position_indicator_events_on(ev_on), .position_indicator_events_off(ev_off),
        .position_indicator_events_stamp(ev_stamp), .irq(irq)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        xs = x ^ (x << 5);
    endfunction : xs
    task automatic fail(input string m);
        mismatches++;
        $display("Error at %0t: %s", $time, m);
    endtask : fail
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) fail("value mismatch");
    endtask : chk_val
    task automatic chk_evt(input logic [3:0] on, input logic [3:0] off, input logic [7:0] e);
        n_checks++;
        if ({on, off} !== e) fail("event mismatch");
    endtask : chk_evt
    task automatic complete_run();
        if (mismatches == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err,
                       output logic [31:0] q);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) fail("no ready");
        q = prdata;
        chk_val(pslverr, err);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic set_ctrl(input logic [1:0] f, input logic r);
        apb(1'b1, ADDR_CTRL, {20'h0, 4'h1, 4'h0, 1'b0, f, r}, 1'b0, rd);
        if (!run_m) filt_m = f;
        run_m = r;
    endtask : set_ctrl
    // note the expected record first; it shows one edge after want moves
    task automatic move(input logic [1:0] nxt);
        logic [3:0] e_on, e_off;
        e_on = (run_m && filt_m != 2'd2) ? 4'h1 << nxt : 4'h0;
        e_off = (run_m && filt_m != 2'd1) ? 4'h1 << cur : 4'h0;
        if (nxt != cur && (e_on | e_off) != 4'h0) exp_q.push_back({e_on, e_off});
        want <= nxt;
        cur = nxt;
        repeat (3) @(posedge pclk);
        chk_val(position, nxt);
    endtask : move

    // ------------------------------------------------------------
    // event monitor and watchdog
    // ------------------------------------------------------------
    always @(posedge pclk) begin
        if (presetn === 1'b1 && ev_valid !== 1'b0) begin
            if (exp_q.size() == 0) fail("unexpected event");
            else begin
                e_pop = exp_q.pop_front();
                chk_evt(ev_on, ev_off, e_pop);
            end
        end
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fail("timeout");
        complete_run();
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_val(position, 0);
        move(2'd3);
        apb(1'b0, 8'h40, 32'h0, 1'b1, rd);
        chk_val(rd, 0);
        apb(1'b1, ADDR_STATUS, 32'h0, 1'b1, rd);
        for (int f = 0; f < 4; f++) begin
            set_ctrl(f[1:0], 1'b0);
            set_ctrl(f[1:0], 1'b1);
            set_ctrl(~f[1:0], 1'b1);
            for (int i = 0; i < 6; i++) begin
                seed = xs(seed);
                noise <= seed[29:16];
                move(seed[1:0] == cur ? cur + 2'd1 : seed[1:0]);
            end
        end
        apb(1'b0, ADDR_STATUS, 32'h0, 1'b0, rd);
        chk_val({rd[4], rd[1:0]}, {1'b1, cur});
        move(2'd1);
        single <= 1'b1;
        for (int i = 1; i < 5; i++) move(i[0] ? 2'd2 : 2'd1);
        // interrupt: off-only filter, but the on bit still flags
        set_ctrl(2'd2, 1'b0);
        set_ctrl(2'd2, 1'b1);
        apb(1'b1, ADDR_IRQ_STATUS, 32'hff, 1'b0, rd);
        apb(1'b1, ADDR_IRQ_MASK, 32'hf, 1'b0, rd);
        move(2'd2);
        chk_val(irq, 1);
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0, 1'b0, rd);
        chk_val(rd, 32'h24);
        apb(1'b1, ADDR_IRQ_STATUS, 32'hff, 1'b0, rd);
        apb(1'b1, ADDR_IRQ_MASK, 32'h0, 1'b0, rd);
        move(2'd1);
        chk_val(irq, 0);
        chk_val(exp_q.size(), 0);
        complete_run();
    end
endmodule : tb_indicator_status_monitor
`default_nettype wire
